/* src/par_pkg.sv */
package par_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 10;
  localparam int ROWS = 1024;
  localparam int COLS = 1024;
  localparam int TIME_W = 32;
  localparam int BUS_AW = 8;
  localparam int BUS_DW = 32;
  localparam int AMP_W = DATA_W + 3;

  localparam logic [DATA_W-1:0] CODE_MAX = 10'h3ff;

  // analog source select codes
  localparam logic [1:0] SRC_PIXEL = 2'h0;
  localparam logic [1:0] SRC_AUX1 = 2'h1;
  localparam logic [1:0] SRC_AUX2 = 2'h2;
  localparam logic [1:0] SRC_AUX3 = 2'h3;

  // gain select codes
  localparam logic [1:0] GAIN_X1 = 2'h0;
  localparam logic [1:0] GAIN_X2 = 2'h1;
  localparam logic [1:0] GAIN_X4 = 2'h2;
  localparam logic [1:0] GAIN_X8 = 2'h3;

  localparam logic POL_INVERT = 1'b0;
  localparam logic POL_STRAIGHT = 1'b1;

  // idle levels of the load and shift clock pins, so no false edge follows reset
  localparam logic LOAD_IDLE = 1'b1;
  localparam logic SHIFT_CLK_IDLE = 1'b1;

  // mosaic phase codes, {row lsb, column lsb}
  localparam logic [1:0] COLOR_RED = 2'h0;

  // register byte offsets
  localparam logic [BUS_AW-1:0] REG_ROW_SEL = 8'h00;
  localparam logic [BUS_AW-1:0] REG_COL_SEL = 8'h04;
  localparam logic [BUS_AW-1:0] REG_INTEG = 8'h08;
  localparam logic [BUS_AW-1:0] REG_CTRL = 8'h0c;
  localparam logic [BUS_AW-1:0] REG_STATUS = 8'h10;

  localparam int CTRL_COLOR_BIT = 0;
  localparam logic CTRL_COLOR_RST = 1'b0;
  localparam int STAT_ROW_ACT_BIT = 0;
  localparam int STAT_ALT_BIT = 1;
endpackage

/* src/par_addr_latch.sv */
`timescale 1ns/1ns
module par_addr_latch (
  input  wire logic                       ref_clk,
  input  wire logic                       rst_b,
  input  wire logic                       load,
  input  wire logic [par_pkg::ADDR_W-1:0] addr_in,
  output logic      [par_pkg::ADDR_W-1:0] addr_q
);
  import par_pkg::*;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
  } par_latch_s;

  par_latch_s st_q;
  par_latch_s st_d;

  always_comb begin
    st_d = st_q;
    // R16: track low, hold high
    if (!load) begin
      st_d.addr = addr_in;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign addr_q = st_q.addr;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  a_latch_holds: assert property (load |=> addr_q == $past(addr_q)) // R16
    else $error("address latch moved while held");
endmodule

/* src/par_adc_out.sv */
`timescale 1ns/1ns
module par_adc_out (
  input  wire logic                       ref_clk,
  input  wire logic                       rst_b,
  input  wire logic                       convert,
  input  wire logic [par_pkg::DATA_W-1:0] sample,
  input  wire logic                       adc_polarity_select,
  input  wire logic                       output_float,
  output logic      [par_pkg::DATA_W-1:0] result_out,
  output logic                            result_oe
);
  import par_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic              oe;
  } par_adc_s;

  par_adc_s st_q;
  par_adc_s st_d;

  always_comb begin
    st_d = st_q;
    // R5: one conversion per falling converter edge
    if (convert) begin
      // R2: polarity 0 inverts every bit
      st_d.data = (adc_polarity_select == POL_INVERT) ? ~sample : sample;
    end
    // R3: float releases the shared bus
    st_d.oe = !output_float;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // R4: parallel word, bit 0 lowest
  assign result_out = st_q.data;
  assign result_oe = st_q.oe;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  a_result_invert: assert property ( // R2
    convert && adc_polarity_select == POL_INVERT |=> result_out == ~$past(sample))
    else $error("result not inverted with polarity low");
  a_result_straight: assert property ( // R2
    convert && adc_polarity_select == POL_STRAIGHT |=> result_out == $past(sample))
    else $error("result altered with polarity high");
  a_float_release: assert property (output_float |=> !result_oe) // R3
    else $error("result driven while floated");
  a_drive_normal: assert property (!output_float |=> result_oe) // R3
    else $error("result not driven in normal mode");
endmodule

/* src/par_readout.sv */
// Overview of operation
// R1: calibrate high makes amplifier output the offset reference at unity gain.
// R2: polarity 0 inverts all result bits; polarity 1 passes them unchanged.
// R3: float 1 releases result outputs; float 0 drives them.
// R4: result is a parallel 10-bit word, lowest bit least significant.
// R5: converter samples on each falling edge of the converter clock.
// R6: one shared 10-bit address bus; top address bit is most significant.
// R7: loading a row address connects that row to column amplifiers.
// R8: latched column address routes that column to the output amplifier.
// R9: row address plus reset input resets every pixel of that row.
// R10: integration time is from last row reset to its readout selection.
// R11: normal reset uses supply level; alternate reset uses alternate voltage.
// R12: controller never asserts alternate reset without dual slope integration.
// R13: readout sampling resets the row; longest integration is between reads.
// R14: array is 1024 by 1024, decoded directly, no shift registers.
// R15: on the color variant pixel row 0, column 0 is red.
// R16: each load input tracks the bus low, holds high, independently.
// R17: source select 00 pixel, 01/10/11 auxiliary inputs one to three.
// R18: gain select 00,01,10,11 gives unity, two, four, eight.
// R19: column register clocks on column shift clock, stable while high.
// R20: controller keeps address stable around load until hold.
// R21: controller latches row, samples, then steps columns clocking converter.
`timescale 1ns/1ns
module par_readout (
  input  wire logic                       ref_clk,
  input  wire logic                       rst_b,
  input  wire logic [par_pkg::ADDR_W-1:0] pixel_address,
  input  wire logic                       row_address_load,
  input  wire logic                       column_address_load,
  input  wire logic                       column_shift_clock,
  input  wire logic                       row_reset,
  input  wire logic                       row_reset_alt_level,
  input  wire logic                       amplifier_calibrate,
  input  wire logic [par_pkg::DATA_W-1:0] offset_reference_level,
  input  wire logic [par_pkg::DATA_W-1:0] pixel_level,
  input  wire logic [par_pkg::DATA_W-1:0] aux_analog_in_one,
  input  wire logic [par_pkg::DATA_W-1:0] aux_analog_in_two,
  input  wire logic [par_pkg::DATA_W-1:0] aux_analog_in_three,
  input  wire logic                       analog_source_select_lo,
  input  wire logic                       analog_source_select_hi,
  input  wire logic                       gain_select_lo,
  input  wire logic                       gain_select_hi,
  input  wire logic                       adc_clock,
  input  wire logic                       adc_polarity_select,
  input  wire logic                       output_float,
  input  wire logic [par_pkg::BUS_AW-1:0] bus_addr,
  input  wire logic [par_pkg::BUS_DW-1:0] bus_wdata,
  input  wire logic                       bus_wr,
  input  wire logic                       bus_rd,
  output logic      [par_pkg::BUS_DW-1:0] bus_rdata,
  output logic      [par_pkg::ADDR_W-1:0] row_selected,
  output logic                            row_connected,
  output logic      [par_pkg::ADDR_W-1:0] column_selected,
  output logic      [par_pkg::DATA_W-1:0] amp_out,
  output logic      [par_pkg::DATA_W-1:0] result_out,
  output logic                            result_oe,
  output logic      [par_pkg::TIME_W-1:0] integration_time,
  output logic                            row_reset_was_alt,
  output logic      [1:0]                 pixel_color
);
  import par_pkg::*;

  typedef struct packed {
    logic [ADDR_W-1:0] col_sel;
    logic              row_act;
    logic [DATA_W-1:0] amp;
    logic [TIME_W-1:0] now;
    logic [TIME_W-1:0] integ;
    logic              rd_pend;
    logic              adc_clk_prev;
    logic              col_clk_prev;
    logic              rst_prev;
    logic              ld_y_prev;
    logic              alt_flag;
    logic [1:0]        color;
    logic              color_en;
    logic [BUS_DW-1:0] rdata;
    logic [ROWS-1:0]   seen;
  } par_top_s;

  par_top_s st_q;
  par_top_s st_d;

  // per-row reset bookkeeping, one word per decoded row
  logic [TIME_W-1:0] stamp_q [ROWS];
  logic              alt_q [ROWS];

  logic [ADDR_W-1:0] row_lat;
  logic [ADDR_W-1:0] col_lat;
  logic [1:0]        src_sel;
  logic [1:0]        gain_sel;
  logic [DATA_W-1:0] src_val;
  logic [AMP_W-1:0]  gained;
  logic              any_reset;
  logic              reset_rise;
  logic              adc_fall;
  logic              select_rise;

  // R6: bus bit 9 carries the top address bit
  // R16: row and column latches load independently
  par_addr_latch u_row_latch (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .load    (row_address_load),
    .addr_in (pixel_address),
    .addr_q  (row_lat)
  );

  par_addr_latch u_col_latch (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .load    (column_address_load),
    .addr_in (pixel_address),
    .addr_q  (col_lat)
  );

  assign src_sel = {analog_source_select_hi, analog_source_select_lo};
  assign gain_sel = {gain_select_hi, gain_select_lo};
  assign any_reset = row_reset | row_reset_alt_level;
  assign reset_rise = any_reset && !st_q.rst_prev;
  // R5: converter clock falling edge
  assign adc_fall = st_q.adc_clk_prev && !adc_clock;
  assign select_rise = row_address_load && !st_q.ld_y_prev;

  always_comb begin
    // R17: analog source multiplexer
    case (src_sel)
      SRC_PIXEL: src_val = pixel_level;
      SRC_AUX1:  src_val = aux_analog_in_one;
      SRC_AUX2:  src_val = aux_analog_in_two;
      SRC_AUX3:  src_val = aux_analog_in_three;
      default:   src_val = pixel_level;
    endcase
    // R18: gain as a left shift
    case (gain_sel)
      GAIN_X1: gained = AMP_W'(src_val);
      GAIN_X2: gained = AMP_W'(src_val) << 1;
      GAIN_X4: gained = AMP_W'(src_val) << 2;
      GAIN_X8: gained = AMP_W'(src_val) << 3;
      default: gained = AMP_W'(src_val);
    endcase
  end

  always_comb begin
    st_d = st_q;
    st_d.now = st_q.now + TIME_W'(1);
    st_d.adc_clk_prev = adc_clock;
    st_d.col_clk_prev = column_shift_clock;
    st_d.rst_prev = any_reset;
    st_d.ld_y_prev = row_address_load;
    st_d.rd_pend = select_rise;
    // R7: row stays connected while its address is held
    st_d.row_act = row_address_load;
    // R8: R19: column register steps on shift clock rise
    if (column_shift_clock && !st_q.col_clk_prev) begin
      st_d.col_sel = col_lat;
    end
    // R1: calibration forces reference at unity gain
    if (amplifier_calibrate) begin
      st_d.amp = offset_reference_level;
    end else if (gained > AMP_W'(CODE_MAX)) begin
      // saturate rather than wrap, like a clipped amplifier
      st_d.amp = CODE_MAX;
    end else begin
      st_d.amp = gained[DATA_W-1:0];
    end
    // R10: integration measured at readout selection
    if (st_q.rd_pend) begin
      st_d.integ = st_q.seen[row_lat] ? st_q.now - stamp_q[row_lat] : '0;
      st_d.alt_flag = st_q.seen[row_lat] && alt_q[row_lat];
    end
    // untouched rows report zero instead of unwritten memory
    if (st_q.rd_pend || reset_rise) begin
      st_d.seen[row_lat] = 1'b1;
    end
    // R15: mosaic phase, red at origin
    st_d.color = st_q.color_en ? {row_lat[0], st_q.col_sel[0]} : COLOR_RED;
    if (bus_wr && bus_addr == REG_CTRL) begin
      st_d.color_en = bus_wdata[CTRL_COLOR_BIT];
    end
    st_d.rdata = '0;
    if (bus_rd) begin
      case (bus_addr)
        REG_ROW_SEL: st_d.rdata = BUS_DW'(row_lat);
        REG_COL_SEL: st_d.rdata = BUS_DW'(st_q.col_sel);
        REG_INTEG:   st_d.rdata = st_q.integ;
        REG_CTRL:    st_d.rdata = BUS_DW'(st_q.color_en);
        REG_STATUS: begin
          st_d.rdata[STAT_ROW_ACT_BIT] = st_q.row_act;
          st_d.rdata[STAT_ALT_BIT] = st_q.alt_flag;
        end
        default:     st_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
      st_q.color_en <= CTRL_COLOR_RST;
      st_q.ld_y_prev <= LOAD_IDLE;
      st_q.col_clk_prev <= SHIFT_CLK_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // R14: decoded row memory, no shift registers
  always_ff @(posedge ref_clk) begin
    // R13: readout sampling restarts the row at supply level
    if (st_q.rd_pend) begin
      stamp_q[row_lat] <= st_q.now;
      alt_q[row_lat] <= 1'b0;
    // R9: R11: explicit reset records its level
    end else if (reset_rise) begin
      stamp_q[row_lat] <= st_q.now;
      alt_q[row_lat] <= row_reset_alt_level && !row_reset;
    end
  end

  par_adc_out u_adc (
    .ref_clk             (ref_clk),
    .rst_b               (rst_b),
    .convert             (adc_fall),
    .sample              (st_q.amp),
    .adc_polarity_select (adc_polarity_select),
    .output_float        (output_float),
    .result_out          (result_out),
    .result_oe           (result_oe)
  );

  assign bus_rdata = st_q.rdata;
  assign row_selected = row_lat;
  assign row_connected = st_q.row_act;
  assign column_selected = st_q.col_sel;
  assign amp_out = st_q.amp;
  assign integration_time = st_q.integ;
  assign row_reset_was_alt = st_q.alt_flag;
  assign pixel_color = st_q.color;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence s_adc_fall;
    adc_clock ##1 !adc_clock;
  endsequence

  sequence s_row_select;
    !row_address_load ##1 row_address_load;
  endsequence

  a_cal_reference: assert property ( // R1
    amplifier_calibrate |=> amp_out == $past(offset_reference_level))
    else $error("calibrate did not force reference level");
  a_source_aux_one: assert property ( // R17
    !amplifier_calibrate && src_sel == SRC_AUX1 && gain_sel == GAIN_X1
    |=> amp_out == $past(aux_analog_in_one))
    else $error("aux input one not routed");
  a_gain_times_two: assert property ( // R18
    !amplifier_calibrate && src_sel == SRC_PIXEL && gain_sel == GAIN_X2
    && pixel_level < 10'h200 |=> amp_out == $past(pixel_level) << 1)
    else $error("gain two not applied");
  a_conv_on_fall: assert property ( // R5
    s_adc_fall ##1 !output_float |=> result_oe && result_oe == 1'b1
    && (result_out == $past(amp_out, 2) || result_out == ~$past(amp_out, 2)))
    else $error("no conversion after falling converter clock");
  a_no_conv_idle: assert property ( // R5
    !adc_fall |=> $stable(result_out))
    else $error("result changed without converter edge");
  a_col_on_clock: assert property ( // R19
    !(column_shift_clock && !st_q.col_clk_prev) |=> $stable(column_selected))
    else $error("column moved without shift clock rise");
  a_row_connect: assert property ( // R7
    s_row_select |=> row_connected)
    else $error("row not connected after load");
  a_integ_time: assert property ( // R10
    st_q.rd_pend && st_q.seen[row_lat]
    |=> integration_time == $past(st_q.now) - $past(stamp_q[row_lat]))
    else $error("integration time wrong");
  a_integ_unseen: assert property ( // R10
    st_q.rd_pend && !st_q.seen[row_lat] |=> integration_time == '0)
    else $error("untouched row reported a nonzero time");
  a_readout_reset: assert property ( // R13
    s_row_select ##1 1'b1 |=> stamp_q[$past(row_lat)] == $past(st_q.now))
    else $error("readout did not restart row");
  a_bayer_origin: assert property ( // R15
    row_lat == '0 && st_q.col_sel == '0 |=> pixel_color == COLOR_RED)
    else $error("origin pixel not red");
  a_alt_level: assert property ( // R11
    reset_rise && !row_reset && !st_q.rd_pend |=> alt_q[$past(row_lat)])
    else $error("alternate reset level not recorded");
  a_alt_normal: assert property ( // R11
    reset_rise && row_reset && !st_q.rd_pend |=> !alt_q[$past(row_lat)])
    else $error("normal reset recorded as alternate");
  a_row_release: assert property (!row_address_load |=> !row_connected) // R7
    else $error("row connected while address tracking");
  a_color_plain: assert property (!st_q.color_en |=> pixel_color == COLOR_RED) // R15
    else $error("mosaic phase shown with variant disabled");
  a_sat_clip: assert property ( // R18
    !amplifier_calibrate && gained > AMP_W'(CODE_MAX) |=> amp_out == CODE_MAX)
    else $error("amplifier wrapped instead of clipping");
  a_source_aux_three: assert property ( // R17
    !amplifier_calibrate && src_sel == SRC_AUX3 && gain_sel == GAIN_X1
    |=> amp_out == $past(aux_analog_in_three))
    else $error("aux input three not routed");
endmodule

/* sim/par_ctrl_model.sv */
`timescale 1ns/1ns
module par_ctrl_model #(
  parameter bit DUAL_SLOPE = 1'b1
) (
  input  wire logic                       ref_clk,
  output logic      [par_pkg::ADDR_W-1:0] pixel_address,
  output logic                            row_address_load,
  output logic                            column_address_load,
  output logic                            column_shift_clock,
  output logic                            row_reset,
  output logic                            row_reset_alt_level,
  output logic                            adc_clock
);
  import par_pkg::*;
  initial begin
    pixel_address = '0;
    row_address_load = 1'b1;
    column_address_load = 1'b1;
    column_shift_clock = 1'b1;
    row_reset = 1'b0;
    row_reset_alt_level = 1'b0;
    adc_clock = 1'b0;
  end
  task automatic latch_row(input logic [ADDR_W-1:0] a);
    @(posedge ref_clk) pixel_address <= a;
    row_address_load <= 1'b0;
    @(posedge ref_clk) row_address_load <= 1'b1;
    // no stale address left on the bus once hold has passed
    @(posedge ref_clk) pixel_address <= ~a;
  endtask
  task automatic step_col(input logic [ADDR_W-1:0] a);
    @(posedge ref_clk) pixel_address <= a;
    column_address_load <= 1'b0;
    @(posedge ref_clk) column_address_load <= 1'b1;
    column_shift_clock <= 1'b0;
    @(posedge ref_clk) pixel_address <= ~a;
    column_shift_clock <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask
  // reset pulse, alt level only in dual slope
  task automatic reset_row(input bit alt);
    @(posedge ref_clk) begin
      if (alt && DUAL_SLOPE) row_reset_alt_level <= 1'b1;
      else row_reset <= 1'b1;
    end
    repeat (2) @(posedge ref_clk);
    row_reset <= 1'b0;
    row_reset_alt_level <= 1'b0;
  endtask
  // one converter clock with a falling edge
  task automatic adc_fall();
    @(posedge ref_clk) adc_clock <= 1'b1;
    repeat (2) @(posedge ref_clk);
    adc_clock <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
endmodule

/* sim/par_readout_test.sv */
`timescale 1ns/1ns
module par_readout_test;
  import par_pkg::*;
  logic ref_clk, rst_b, cal, src_lo, src_hi, g_lo, g_hi, pol, flt, bus_wr, bus_rd;
  logic [DATA_W-1:0] ofs, pix, aux1, aux2, aux3;
  logic [BUS_AW-1:0] bus_addr;
  logic [BUS_DW-1:0] bus_wdata, bus_rdata, rd_v;
  logic [ADDR_W-1:0] pa, row_sel, col_sel;
  logic ld_r, ld_c, sclk, rrst, ralt, aclk, row_con, oe, was_alt;
  logic [DATA_W-1:0] amp, res;
  logic [TIME_W-1:0] integ, t1;
  logic [1:0] color;
  int failures = 0;
  int compares = 0;
  par_ctrl_model ctl_u (.ref_clk(ref_clk), .pixel_address(pa), .row_address_load(ld_r),
    .column_address_load(ld_c), .column_shift_clock(sclk), .row_reset(rrst),
    .row_reset_alt_level(ralt), .adc_clock(aclk));
  par_readout dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .pixel_address(pa),
    .row_address_load(ld_r), .column_address_load(ld_c), .column_shift_clock(sclk),
    .row_reset(rrst), .row_reset_alt_level(ralt), .amplifier_calibrate(cal),
    .offset_reference_level(ofs), .pixel_level(pix), .aux_analog_in_one(aux1),
    .aux_analog_in_two(aux2), .aux_analog_in_three(aux3), .analog_source_select_lo(src_lo),
    .analog_source_select_hi(src_hi), .gain_select_lo(g_lo), .gain_select_hi(g_hi),
    .adc_clock(aclk), .adc_polarity_select(pol), .output_float(flt), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .row_selected(row_sel), .row_connected(row_con), .column_selected(col_sel),
    .amp_out(amp), .result_out(res), .result_oe(oe), .integration_time(integ),
    .row_reset_was_alt(was_alt), .pixel_color(color));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [BUS_AW-1:0] a, input logic [BUS_DW-1:0] d);
    @(posedge ref_clk) bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge ref_clk) bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [BUS_AW-1:0] a);
    @(posedge ref_clk) bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge ref_clk) bus_rd <= 1'b0;
    #1 rd_v = bus_rdata;
  endtask
  // amplifier inputs settle one registered cycle later
  task automatic amp_set(input logic [1:0] s, input logic [1:0] g, input logic c);
    @(posedge ref_clk) src_hi <= s[1];
    src_lo <= s[0];
    g_hi <= g[1];
    g_lo <= g[0];
    cal <= c;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  task automatic t_amp();
    logic [DATA_W-1:0] lv [4];
    logic [DATA_W-1:0] gx [4];
    lv = '{10'h011, 10'h122, 10'h233, 10'h344};
    gx = '{10'h05a, 10'h0b4, 10'h168, 10'h2d0};
    for (int i = 0; i < 4; i++) begin
      amp_set(i[1:0], GAIN_X1, 1'b0);
      chk(32'(amp), 32'(lv[i]));
    end
    @(posedge ref_clk) aux1 <= 10'h05a;
    for (int i = 0; i < 4; i++) begin
      amp_set(SRC_AUX1, i[1:0], 1'b0);
      chk(32'(amp), 32'(gx[i]));
    end
    @(posedge ref_clk) aux1 <= 10'h090;
    amp_set(SRC_AUX1, GAIN_X8, 1'b0);
    chk(32'(amp), 32'(CODE_MAX));
    amp_set(SRC_AUX2, GAIN_X8, 1'b1);
    chk(32'(amp), 32'(ofs));
    @(posedge ref_clk) pix <= 10'h0c3;
    ofs <= 10'h15a;
    aux2 <= 10'h0f0;
    aux3 <= 10'h21e;
    amp_set(SRC_PIXEL, GAIN_X2, 1'b0);
    chk(32'(amp), 32'h186);
    amp_set(SRC_AUX3, GAIN_X1, 1'b0);
    chk(32'(amp), 32'h21e);
    amp_set(SRC_AUX2, GAIN_X4, 1'b0);
    chk(32'(amp), 32'h3c0);
    amp_set(SRC_PIXEL, GAIN_X8, 1'b1);
    chk(32'(amp), 32'h15a);
    $display("test amplifier done");
  endtask
  task automatic t_adc();
    @(posedge ref_clk) aux1 <= 10'h2c5;
    pol <= POL_STRAIGHT;
    flt <= 1'b0;
    amp_set(SRC_AUX1, GAIN_X1, 1'b0);
    ctl_u.adc_fall();
    chk(32'(res), 32'h2c5);
    chk(32'(oe), 32'h1);
    @(posedge ref_clk) pol <= POL_INVERT;
    aux1 <= 10'h000;
    repeat (3) @(posedge ref_clk);
    chk(32'(res), 32'h2c5);
    ctl_u.adc_fall();
    chk(32'(res), 32'h3ff);
    @(posedge ref_clk) flt <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 chk(32'(oe), 32'h0);
    $display("test converter done");
  endtask
  task automatic t_addr();
    ctl_u.latch_row(10'h201);
    #1 chk(32'(row_sel), 32'h201);
    @(posedge ref_clk) #1 chk(32'(row_con), 32'h1);
    repeat (4) @(posedge ref_clk);
    chk(32'(row_sel), 32'h201);
    ctl_u.latch_row(10'h3ff);
    #1 chk(32'(row_sel), 32'h3ff);
    ctl_u.step_col(10'h155);
    #1 chk(32'(col_sel), 32'h155);
    chk(32'(row_sel), 32'h3ff);
    rd(REG_COL_SEL);
    chk(rd_v, 32'h155);
    $display("test addressing done");
  endtask
  task automatic t_integ();
    ctl_u.latch_row(10'h005);
    repeat (37) @(posedge ref_clk);
    ctl_u.latch_row(10'h005);
    repeat (3) @(posedge ref_clk);
    #1 chk(integ, 32'd40);
    ctl_u.reset_row(1'b0);
    repeat (10) @(posedge ref_clk);
    ctl_u.latch_row(10'h005);
    repeat (3) @(posedge ref_clk);
    #1 t1 = integ;
    chk(32'(was_alt), 32'h0);
    ctl_u.reset_row(1'b1);
    repeat (17) @(posedge ref_clk);
    ctl_u.latch_row(10'h005);
    repeat (3) @(posedge ref_clk);
    #1 chk(integ - t1, 32'd7);
    chk(32'(was_alt), 32'h1);
    rd(REG_STATUS);
    chk(rd_v, 32'h3);
    rd(REG_INTEG);
    chk(rd_v, 32'd22);
    $display("test integration done");
  endtask
  task automatic t_regs();
    rd(8'h14);
    chk(rd_v, 32'h0);
    wr(REG_ROW_SEL, 32'h0000_0077);
    rd(REG_ROW_SEL);
    chk(rd_v, 32'h005);
    rd(REG_CTRL);
    chk(rd_v, 32'(CTRL_COLOR_RST));
    wr(REG_CTRL, 32'h1);
    rd(REG_CTRL);
    chk(rd_v, 32'h1);
    $display("test registers done");
  endtask
  task automatic t_color();
    ctl_u.latch_row(10'h000);
    ctl_u.step_col(10'h000);
    #1 chk(32'(color), 32'(COLOR_RED));
    ctl_u.latch_row(10'h001);
    ctl_u.step_col(10'h000);
    #1 chk(32'(color), 32'h2);
    $display("test mosaic done");
  endtask
  task automatic wrap_up();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    rst_b = 1'b0;
    cal = 1'b0;
    src_lo = 1'b0;
    src_hi = 1'b0;
    g_lo = 1'b0;
    g_hi = 1'b0;
    pol = 1'b0;
    flt = 1'b0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    ofs = 10'h0a5;
    pix = 10'h011;
    aux1 = 10'h122;
    aux2 = 10'h233;
    aux3 = 10'h344;
    bus_addr = '0;
    bus_wdata = '0;
    repeat (10) @(posedge ref_clk);
    #1 chk(32'(oe), 32'h0);
    @(posedge ref_clk) rst_b <= 1'b1;
    t_amp();
    t_adc();
    t_addr();
    t_integ();
    t_regs();
    t_color();
    wrap_up();
  end
  // whole run is well under 1000 cycles
  initial begin
    #20000;
    failures++;
    wrap_up();
  end
endmodule
